// >>> core/ams_map.svh
// register map, field positions, codes and timing constants of the converter mode sequencer
`ifndef AMS_MAP_SVH
`define AMS_MAP_SVH

// register byte offsets
`define AMS_CTRL_OFS 8'h00
`define AMS_STAT_OFS 8'h04
`define AMS_DATA_OFS 8'h08

// control register fields
`define AMS_MODE_LSB 0
`define AMS_CHAN_LSB 4
`define AMS_RATE_LSB 8
`define AMS_DIV18_BIT 12

// status register fields
`define AMS_STAT_FLAG_BIT 0
`define AMS_STAT_BUSY_BIT 1
`define AMS_STAT_LEVEL_LSB 4

// operating mode codes
`define AMS_MODE_SLEEP 2'h0
`define AMS_MODE_SINGLE 2'h1
`define AMS_MODE_SOFT 2'h2
`define AMS_MODE_CONT 2'h3

// converter shape
`define AMS_RES_W 10
`define AMS_CHAN_W 3
`define AMS_TEMP_CHAN 3'h0
`define AMS_FIFO_DEPTH 8
`define AMS_LEVEL_W 4

// continuous-mode divider
`define AMS_DIV_LONG 36
`define AMS_DIV_SHORT 18
`define AMS_RATE_EXP_OFS 2

// timing: clock rate and the allowed sample-rate window
`define AMS_CLK_HZ 200000000
`define AMS_FS_MAX_HZ 32000
`define AMS_FS_MIN_HZ 1000
`define AMS_MIN_PERIOD_CYC ((`AMS_CLK_HZ + `AMS_FS_MAX_HZ - 1) / `AMS_FS_MAX_HZ)
`define AMS_MAX_PERIOD_CYC (`AMS_CLK_HZ / `AMS_FS_MIN_HZ)

`endif

// >>> core/ams_pkg.sv
// types shared by the converter mode sequencer
`include "ams_map.svh"
package ams_pkg;

    // sequencer state
    typedef enum logic {
        AMS_IDLE,
        AMS_BUSY
    } ams_seq_t;

    // state of the top module, apart from the fifo and the gap_q / gap_arm rate-check helper
    typedef struct packed {
        ams_seq_t state;
        logic [1:0] mode;
        logic [`AMS_CHAN_W-1:0] chan;
        logic [3:0] rate;
        logic div18;
        logic [23:0] cnt;
        logic tick;
        logic start;
        logic [`AMS_CHAN_W-1:0] chan_cv;
        logic pwr;
        logic temp_en;
        logic irq;
        logic ap;
        logic [7:0] a_addr;
        logic a_wr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } ams_top_state_t;

endpackage : ams_pkg

// >>> core/ams_fifo.sv
// result fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ams_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    // fill level
    output logic [$clog2(D+1)-1:0] count
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } ams_fifo_state_t;

    ams_fifo_state_t s_r;
    ams_fifo_state_t s_nxt;
    logic do_in;
    logic do_out;

    // honest flags straight from the count
    assign in_ready = (s_r.cnt != CW'(D));
    assign out_valid = (s_r.cnt != '0);
    assign out_data = s_r.mem[s_r.rp];
    assign count = s_r.cnt;
    assign do_in = in_valid & in_ready;
    assign do_out = out_valid & out_ready;

    // pointer wrap written out so depths that are not powers of two still work
    always_comb begin
        s_nxt = s_r;
        if (do_in) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + AW'(1);
        end
        if (do_out) begin
            s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + AW'(1);
        end
        s_nxt.cnt = s_r.cnt + CW'(do_in) - CW'(do_out);
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : ams_fifo
`default_nettype wire

// >>> core/ams_top.sv
// converter mode sequencer: ahb-lite registers, mode control, rate divider and result fifo
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ams_map.svh"
module ams_top #(
    parameter int MIN_PERIOD = `AMS_MIN_PERIOD_CYC,
    parameter int MAX_PERIOD = `AMS_MAX_PERIOD_CYC
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // analog converter core
    input wire logic CONV_DONE,
    input wire logic [`AMS_RES_W-1:0] CONV_RESULT,
    output logic CONV_PWR_ON,
    output logic CONV_START,
    output logic [`AMS_CHAN_W-1:0] CONV_CHAN,
    output logic TEMP_SENSE_EN,
    // to the interrupt control unit
    output logic ADC_IRQ
);
    ams_pkg::ams_top_state_t s_r;
    ams_pkg::ams_top_state_t s_nxt;

    logic accept;
    logic wr_ctrl;
    logic rd_data;
    logic push;
    logic pop;
    logic abort;
    logic go;
    logic [1:0] new_mode;
    logic [23:0] period_raw;
    logic [23:0] period;
    logic fifo_ir;
    logic fifo_ov;
    logic [`AMS_RES_W-1:0] fifo_od;
    logic [`AMS_LEVEL_W-1:0] fifo_cnt;

    // outputs come straight from the state register
    assign HREADYOUT = s_r.hready;
    assign HRESP = s_r.hresp;
    assign HRDATA = s_r.hrdata;
    assign CONV_PWR_ON = s_r.pwr;
    assign CONV_START = s_r.start;
    assign CONV_CHAN = s_r.chan_cv;
    assign TEMP_SENSE_EN = s_r.temp_en;
    assign ADC_IRQ = s_r.irq;

    // bus decode; the data phase is the cycle after an accepted address phase
    assign accept = HSEL & HREADY & HTRANS[1];
    assign wr_ctrl = s_r.ap & s_r.a_wr & (s_r.a_addr == `AMS_CTRL_OFS);
    assign rd_data = s_r.ap & ~s_r.a_wr & (s_r.a_addr == `AMS_DATA_OFS);
    assign new_mode = HWDATA[`AMS_MODE_LSB +: 2];

    // reading the result pops it, which is what clears the completion flag
    assign pop = rd_data & fifo_ov;
    // room is checked before each start, so a finished result always fits
    assign push = (s_r.state == ams_pkg::AMS_BUSY) & CONV_DONE & fifo_ir;
    assign abort = wr_ctrl & (new_mode == `AMS_MODE_SLEEP) & (s_r.state == ams_pkg::AMS_BUSY);

    // start condition per mode
    assign go = (s_r.mode == `AMS_MODE_SINGLE)
        | ((s_r.mode == `AMS_MODE_SOFT) & ~fifo_ov)
        | ((s_r.mode == `AMS_MODE_CONT) & s_r.tick);

    // sample period = (36 or 18) << (rate + 2), clamped to the 1 kHz .. 32 kHz window
    assign period_raw = (s_r.div18 ? 24'(`AMS_DIV_SHORT) : 24'(`AMS_DIV_LONG))
        << (5'(s_r.rate) + 5'(`AMS_RATE_EXP_OFS));
    assign period = (period_raw < 24'(MIN_PERIOD)) ? 24'(MIN_PERIOD)
        : (period_raw > 24'(MAX_PERIOD)) ? 24'(MAX_PERIOD) : period_raw;

    // result buffer; a full buffer stalls the sequencer rather than losing samples
    ams_fifo #(
        .W(`AMS_RES_W),
        .D(`AMS_FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst_b(RST_B),
        .in_valid(push),
        .in_data(CONV_RESULT),
        .in_ready(fifo_ir),
        .out_valid(fifo_ov),
        .out_data(fifo_od),
        .out_ready(pop),
        .count(fifo_cnt)
    );

    // next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.ap = 1'b0;
        s_nxt.hready = 1'b1;
        // one wait state on every transfer so read data can come from a flop
        if (accept) begin
            s_nxt.ap = 1'b1;
            s_nxt.hready = 1'b0;
            s_nxt.a_addr = HADDR[7:0];
            s_nxt.a_wr = HWRITE;
        end
        if (s_r.ap && !s_r.a_wr) begin
            s_nxt.hrdata = 32'h0;
            unique case (s_r.a_addr)
                `AMS_CTRL_OFS: begin
                    s_nxt.hrdata[`AMS_MODE_LSB +: 2] = s_r.mode;
                    s_nxt.hrdata[`AMS_CHAN_LSB +: `AMS_CHAN_W] = s_r.chan;
                    s_nxt.hrdata[`AMS_RATE_LSB +: 4] = s_r.rate;
                    s_nxt.hrdata[`AMS_DIV18_BIT] = s_r.div18;
                end
                `AMS_STAT_OFS: begin
                    s_nxt.hrdata[`AMS_STAT_FLAG_BIT] = fifo_ov;
                    s_nxt.hrdata[`AMS_STAT_BUSY_BIT] = (s_r.state == ams_pkg::AMS_BUSY);
                    s_nxt.hrdata[`AMS_STAT_LEVEL_LSB +: `AMS_LEVEL_W] = fifo_cnt;
                end
                `AMS_DATA_OFS: begin
                    s_nxt.hrdata[`AMS_RES_W-1:0] = fifo_ov ? fifo_od : '0;
                end
                default: begin
                    s_nxt.hrdata = 32'h0;
                end
            endcase
        end
        // continuous-mode sample tick; held until the sequencer can use it
        if (s_r.mode == `AMS_MODE_CONT) begin
            if (s_r.cnt >= period - 24'd1) begin
                s_nxt.cnt = 24'h0;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 24'd1;
            end
        end else begin
            s_nxt.cnt = 24'h0;
            s_nxt.tick = 1'b0;
        end
        // sequencer
        unique case (s_r.state)
            ams_pkg::AMS_IDLE: begin
                if (go && fifo_ir) begin
                    s_nxt.state = ams_pkg::AMS_BUSY;
                    s_nxt.start = 1'b1;
                    s_nxt.chan_cv = s_r.chan;
                    s_nxt.tick = 1'b0;
                end
            end
            ams_pkg::AMS_BUSY: begin
                if (push) begin
                    s_nxt.state = ams_pkg::AMS_IDLE;
                    if (s_r.mode == `AMS_MODE_SINGLE) begin
                        s_nxt.mode = `AMS_MODE_SLEEP;
                    end
                end
            end
        endcase
        // software write comes last so it wins over the automatic return to sleep
        if (wr_ctrl) begin
            s_nxt.mode = new_mode;
            s_nxt.chan = HWDATA[`AMS_CHAN_LSB +: `AMS_CHAN_W];
            s_nxt.rate = HWDATA[`AMS_RATE_LSB +: 4];
            s_nxt.div18 = HWDATA[`AMS_DIV18_BIT];
        end
        if (abort) begin
            s_nxt.state = ams_pkg::AMS_IDLE;
        end
        // sleep powers the core down at once; channel 0 also powers the sensor
        s_nxt.pwr = (s_nxt.mode != `AMS_MODE_SLEEP);
        s_nxt.temp_en = s_nxt.pwr & (s_nxt.chan_cv == `AMS_TEMP_CHAN);
        // flag is simply "a result is waiting"; a push in the pop cycle keeps it set
        s_nxt.irq = fifo_ov;
    end

    // state register
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s_r <= '0;
            s_r.hready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // helper: cycles since the last start, for the sample-rate check
    logic [23:0] gap_q;
    logic gap_arm;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            gap_q <= 24'h0;
            gap_arm <= 1'b0;
        end else begin
            gap_q <= CONV_START ? 24'h0 : gap_q + 24'd1;
            gap_arm <= (s_r.mode == `AMS_MODE_CONT) & (gap_arm | CONV_START);
        end
    end

    property p_sleep_quiet;
        @(posedge CLOCK) disable iff (!RST_B)
        (s_r.mode == `AMS_MODE_SLEEP) && (s_r.state == ams_pkg::AMS_IDLE) |=> !CONV_START;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("start issued in sleep");

    property p_sleep_power;
        @(posedge CLOCK) disable iff (!RST_B)
        $rose(s_r.mode == `AMS_MODE_SLEEP) |-> !CONV_PWR_ON && !TEMP_SENSE_EN;
    endproperty
    a_sleep_power: assert property (p_sleep_power) else $error("core powered in sleep");

    property p_single_back;
        @(posedge CLOCK) disable iff (!RST_B)
        push && (s_r.mode == `AMS_MODE_SINGLE) && !wr_ctrl |=> (s_r.mode == `AMS_MODE_SLEEP) ##1 !CONV_START;
    endproperty
    a_single_back: assert property (p_single_back) else $error("single mode did not return to sleep");

    property p_flag_set;
        @(posedge CLOCK) disable iff (!RST_B)
        push && !pop |=> fifo_ov ##1 (ADC_IRQ || $past(pop));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("completion flag not raised");

    property p_soft_wait;
        @(posedge CLOCK) disable iff (!RST_B)
        CONV_START && (s_r.mode == `AMS_MODE_SOFT) |-> !$past(fifo_ov);
    endproperty
    a_soft_wait: assert property (p_soft_wait) else $error("software mode restarted before read");

    property p_read_clears;
        @(posedge CLOCK) disable iff (!RST_B)
        pop && !push |=> fifo_cnt == $past(fifo_cnt) - 4'd1;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("result read did not pop");

    property p_rate;
        @(posedge CLOCK) disable iff (!RST_B)
        CONV_START && gap_arm && (s_r.mode == `AMS_MODE_CONT) |-> gap_q >= 24'(MIN_PERIOD - 1);
    endproperty
    a_rate: assert property (p_rate) else $error("sample rate above ceiling");

    property p_temp;
        @(posedge CLOCK) disable iff (!RST_B)
        CONV_START && (CONV_CHAN == `AMS_TEMP_CHAN) |-> TEMP_SENSE_EN;
    endproperty
    a_temp: assert property (p_temp) else $error("temperature sensor not enabled");

    property p_abort;
        @(posedge CLOCK) disable iff (!RST_B)
        // a result landing in the abort cycle is kept, so that cycle is left out here
        abort && !push |=> (s_r.state == ams_pkg::AMS_IDLE) && !CONV_PWR_ON
            && (fifo_cnt == $past(fifo_cnt) - 4'($past(pop)));
    endproperty
    a_abort: assert property (p_abort) else $error("sleep write did not abort");

    property p_bus_wait;
        @(posedge CLOCK) disable iff (!RST_B)
        accept |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer timing wrong");

endmodule : ams_top
`default_nettype wire

// >>> tb/ams_core_model.sv
// behavioural model of the analog converter core driven by the sequencer
`timescale 1ns/1ps
`default_nettype none
module ams_core_model #(
    parameter int DLY = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // from the sequencer
    input wire logic start,
    input wire logic [2:0] chan,
    // back to the sequencer
    output logic done,
    output logic [9:0] result
);
    logic [6:0] seq_r;
    logic [2:0] ch_r;
    int cnt_r;

    // one done pulse per start after a fixed latency; result outside done is scrambled on purpose
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
            result <= 10'h000;
            seq_r <= 7'h00;
            ch_r <= 3'h0;
            cnt_r <= 0;
        end else begin
            done <= 1'b0;
            result <= ~result;
            if (start) begin
                cnt_r <= DLY;
                ch_r <= chan;
            end else if (cnt_r == 1) begin
                done <= 1'b1;
                result <= {ch_r, seq_r};
                seq_r <= seq_r + 7'h01;
                cnt_r <= 0;
            end else if (cnt_r > 1) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule : ams_core_model
`default_nettype wire

// >>> tb/ams_top_test.sv
// self-checking bench of the converter mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ams_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module ams_top_test;
    localparam int LIMIT = 20000; // whole run needs well under half of this
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    wire HREADYOUT, HRESP, CONV_DONE, CONV_PWR_ON, CONV_START, TEMP_SENSE_EN, ADC_IRQ;
    wire [31:0] HRDATA;
    wire [9:0] CONV_RESULT;
    wire [2:0] CONV_CHAN;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int nst = 0;
    int ndone = 0;
    int st_q[$];
    logic [31:0] rd;

    // short clamp window keeps continuous runs brief
    ams_top #(.MIN_PERIOD(100), .MAX_PERIOD(400)) dut (.CLOCK(CLOCK), .RST_B(RST_B), .HSEL(1'b1),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .CONV_DONE(CONV_DONE),
        .CONV_RESULT(CONV_RESULT), .CONV_PWR_ON(CONV_PWR_ON), .CONV_START(CONV_START),
        .CONV_CHAN(CONV_CHAN), .TEMP_SENSE_EN(TEMP_SENSE_EN), .ADC_IRQ(ADC_IRQ));
    ams_core_model #(.DLY(10)) core (.clk(CLOCK), .rst_b(RST_B), .start(CONV_START), .chan(CONV_CHAN),
        .done(CONV_DONE), .result(CONV_RESULT));

    always #2.5 CLOCK = ~CLOCK;

    // start times and done count for expectations; also the hang limit
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (CONV_START === 1'b1) begin
            nst <= nst + 1;
            st_q.push_back(cyc);
        end
        if (CONV_DONE === 1'b1) ndone <= ndone + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // one single word transfer; ready is judged at the rising edge itself, before the design updates
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLOCK);
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        `CHK("hresp", 1'b0, HRESP)
    endtask : bus

    task automatic wr_ctrl(input logic [1:0] m, input logic [2:0] ch, input logic [3:0] rt, input logic d18);
        bus(1'b1, `AMS_CTRL_OFS, {19'h0, d18, rt, 1'b0, ch, 2'h0, m});
    endtask : wr_ctrl

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (ADC_IRQ !== lvl && n < 2000) begin
            @(negedge CLOCK);
            n++;
        end
        `CHK("irq", lvl, ADC_IRQ)
    endtask : wait_irq

    task automatic rd_data(input logic [9:0] ex);
        bus(1'b0, `AMS_DATA_OFS, 32'h0);
        `CHK("data", {22'h0, ex}, rd)
    endtask : rd_data

    task automatic t_reset();
        `CHK("pwr", 1'b0, CONV_PWR_ON)
        bus(1'b0, `AMS_CTRL_OFS, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        bus(1'b0, 8'h0c, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask : t_reset

    // every channel once, each needing its own mode write
    task automatic t_single();
        for (int c = 0; c < 8; c++) begin
            wr_ctrl(`AMS_MODE_SINGLE, c[2:0], 4'h0, 1'b0);
            repeat (3) @(negedge CLOCK);
            `CHK("pwr", 1'b1, CONV_PWR_ON)
            `CHK("chan", c[2:0], CONV_CHAN)
            `CHK("temp", c == 0, TEMP_SENSE_EN)
            wait_irq(1'b1);
            `CHK("pwr off", 1'b0, CONV_PWR_ON)
            bus(1'b0, `AMS_STAT_OFS, 32'h0);
            `CHK("flag", 1'b1, rd[0])
            rd_data({c[2:0], 7'(ndone - 1)});
            wait_irq(1'b0);
            repeat (20) @(negedge CLOCK);
            `CHK("one start", c + 1, nst)
        end
    endtask : t_single

    task automatic period(input logic [3:0] rt, input logic d18, input int ex);
        int b;
        int n;
        b = st_q.size();
        n = 0;
        wr_ctrl(`AMS_MODE_CONT, 3'h3, rt, d18);
        while (st_q.size() < b + 3 && n < 3000) begin
            @(negedge CLOCK);
            n++;
        end
        `CHK("period", ex, st_q[b + 2] - st_q[b + 1])
        wr_ctrl(`AMS_MODE_SLEEP, 3'h0, 4'h0, 1'b0);
        repeat (9) bus(1'b0, `AMS_DATA_OFS, 32'h0);
    endtask : period

    // fill until the buffer refuses, stop, then every queued result is still there
    task automatic t_fill();
        int b;
        int s;
        b = ndone;
        s = nst;
        wr_ctrl(`AMS_MODE_CONT, 3'h6, 4'h0, 1'b1);
        repeat (1300) @(negedge CLOCK);
        `CHK("starts", s + 8, nst)
        bus(1'b0, `AMS_STAT_OFS, 32'h0);
        `CHK("level", 4'h8, rd[7:4])
        wr_ctrl(`AMS_MODE_SLEEP, 3'h0, 4'h0, 1'b0);
        for (int i = 0; i < 8; i++) rd_data({3'h6, 7'(b + i)});
        wait_irq(1'b0);
        rd_data(10'h000);
    endtask : t_fill

    // software mode waits for the read, restarts, then sleep aborts a conversion in flight
    task automatic t_soft();
        int s;
        s = nst;
        wr_ctrl(`AMS_MODE_SOFT, 3'h5, 4'h0, 1'b0);
        bus(1'b0, `AMS_STAT_OFS, 32'h0);
        `CHK("busy", 1'b1, rd[1])
        wait_irq(1'b1);
        repeat (30) @(negedge CLOCK);
        `CHK("waits", s + 1, nst)
        rd_data({3'h5, 7'(ndone - 1)});
        wait_irq(1'b0);
        wait_irq(1'b1);
        `CHK("restart", s + 2, nst)
        rd_data({3'h5, 7'(ndone - 1)});
        wr_ctrl(`AMS_MODE_SLEEP, 3'h0, 4'h0, 1'b0);
        repeat (30) @(negedge CLOCK);
        `CHK("aborted", 1'b0, ADC_IRQ)
        `CHK("pwr", 1'b0, CONV_PWR_ON)
        `CHK("no restart", s + 3, nst)
    endtask : t_soft

    initial begin
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        t_reset();
        t_single();
        period(4'h0, 1'b1, 100);
        period(4'h0, 1'b0, 144);
        period(4'h1, 1'b1, 144);
        period(4'hf, 1'b0, 400);
        t_fill();
        t_soft();
        print_verdict();
    end
endmodule : ams_top_test
`default_nettype wire
